// *** core/pim_defines.vh ***
// Notes on behaviour
// - Interrupt register bits 15..8 are event flags for link quality, energy detect, link, speed, duplex, autoneg done, false carrier and receive half-full.
// - Interrupt register bits 7..0 are read/write enables, reset to zero, each gating the flag eight places above it.
// - With command field 0 the address/data register reaches the selected MMD's address pointer.
// - With command field 1 the address/data register reaches MMD data and leaves the pointer alone.
// - With command field 2 the pointer advances after every data read and every data write.
// - With command field 3 the pointer advances after data writes only.
// - The five-bit selector in control bits 4..0 steers indirect accesses; the vendor code reaches registers up to 0x04d1.
// - Selector 00011 reaches MMD3 and selector 00111 reaches MMD7.
// - An indirect access with an unsupported selector is ignored and changes nothing.
// - Link-drop status bits 8..4 latch high when their enabled fast link-drop condition drops the link.
// - Status encoding is 0x1 energy loss, 0x2 SNR, 0x4 MLT3 errors, 0x8 receive errors, 0x10 descrambler sync loss.
// - The receive-error condition drops the link after 32 errors within 10 us.
// - The MLT3 condition drops the link after 20 coding errors within 10 us.
`ifndef PIM_DEFINES_VH
`define PIM_DEFINES_VH
// ============================================================
// Register offsets
`define PIM_OFS_IRQ 5'h0c
`define PIM_OFS_CTRL 5'h0d
`define PIM_OFS_ADDAT 5'h0e
`define PIM_OFS_DROP 5'h0f
`define PIM_RESET_VAL 16'h0000
// ============================================================
// Control field positions and codes
`define PIM_CMD_HI 15
`define PIM_CMD_LO 14
`define PIM_CMD_ADDR 2'h0
`define PIM_CMD_DATA 2'h1
`define PIM_CMD_INC_RW 2'h2
`define PIM_CMD_INC_W 2'h3
`define PIM_SEL_VEND 5'h1f
`define PIM_SEL_MMD3 5'h03
`define PIM_SEL_MMD7 5'h07
`define PIM_VEND_MAX 16'h04d1
// ============================================================
// Link-drop status positions and timing
`define PIM_DROP_LO 4
`define PIM_DROP_HI 8
`define PIM_RXERR_LIMIT 32
`define PIM_MLT3_LIMIT 20
`define PIM_SNR_LIMIT 20
`define PIM_WIN_NS 10000
`define PIM_CLK_NS 10
`define PIM_WIN_CYC (`PIM_WIN_NS / `PIM_CLK_NS)
`endif

// *** core/pim_win_counter.v ***
`timescale 1ns/1ps
`include "pim_defines.vh"
// Counts event pulses in fixed windows and trips once the limit is reached.
module pim_win_counter #(
  parameter LIMIT = 32,
  parameter WIN_CYC = `PIM_WIN_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Condition
  input wire enable,
  input wire event_in,
  output reg trip_q
);
  reg [15:0] win_q;
  reg [7:0] cnt_q;
  wire win_end = (win_q == WIN_CYC[15:0] - 16'h0001);
  wire [7:0] cnt_inc = cnt_q + {7'h00, event_in};

  // ============================================================
  // Window and count
  // Fixed windows are simpler than a sliding one; a burst that straddles
  // a window boundary is split between two counts and may not trip at all.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_q <= 16'h0000;
      cnt_q <= 8'h00;
      trip_q <= 1'b0;
    end
    else
    begin
      win_q <= win_end ? 16'h0000 : win_q + 16'h0001;
      trip_q <= 1'b0;
      if (!enable)
        cnt_q <= 8'h00;
      else if (cnt_inc >= LIMIT[7:0])
      begin
        trip_q <= 1'b1;
        cnt_q <= 8'h00;
      end
      else if (win_end)
        cnt_q <= 8'h00;
      else
        cnt_q <= cnt_inc;
    end
  end
endmodule

// *** core/pim_regs.v ***
`timescale 1ns/1ps
`include "pim_defines.vh"
module pim_regs (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Management register port
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_q,
  // Event pulses, order link quality .. receive half-full
  input wire [7:0] irq_event,
  output wire irq_active,
  // MMD storage port
  output wire mmd_wr,
  output wire mmd_rd,
  output wire [4:0] mmd_selector,
  output wire [15:0] mmd_addr,
  output wire [15:0] mmd_wdata,
  input wire [15:0] mmd_rdata,
  // Fast link-drop conditions, enables in status-bit order
  input wire [4:0] drop_enable,
  input wire energy_lost,
  input wire snr_cross,
  input wire mlt3_err,
  input wire rx_err,
  input wire descr_loss,
  output reg link_drop_q
);
  reg [7:0] irq_flag_q;
  reg [7:0] irq_en_q;
  reg [1:0] cmd_q;
  reg [4:0] sel_q;
  reg [15:0] ptr_q [0:2];
  reg [4:0] drop_stat_q;
  reg energy_lost_q;
  reg descr_loss_q;
  wire [4:0] drop_cause;
  wire trip_snr;
  wire trip_mlt3;
  wire trip_rx;

  // ============================================================
  // Selector decode, 3 means unsupported
  function [1:0] sel_idx;
    input [4:0] sel;
    begin
      case (sel)
        `PIM_SEL_VEND: sel_idx = 2'd0;
        `PIM_SEL_MMD3: sel_idx = 2'd1;
        `PIM_SEL_MMD7: sel_idx = 2'd2;
        default: sel_idx = 2'd3;
      endcase
    end
  endfunction

  wire [1:0] idx = sel_idx(sel_q);
  wire sel_ok = (idx != 2'd3);
  wire [15:0] cur_ptr = sel_ok ? ptr_q[idx] : 16'h0000;
  wire hit_ad = (reg_addr == `PIM_OFS_ADDAT);
  wire data_mode = (cmd_q != `PIM_CMD_ADDR);
  wire ad_wr = reg_wr && hit_ad && sel_ok;
  wire ad_rd = reg_rd && hit_ad && sel_ok;
  wire inc = data_mode && ((ad_rd && cmd_q == `PIM_CMD_INC_RW) ||
    (ad_wr && (cmd_q == `PIM_CMD_INC_RW || cmd_q == `PIM_CMD_INC_W)));

  assign mmd_wr = ad_wr && data_mode;
  assign mmd_rd = ad_rd && data_mode;
  assign mmd_selector = sel_q;
  assign mmd_addr = cur_ptr;
  assign mmd_wdata = reg_wdata;
  assign irq_active = |(irq_flag_q & irq_en_q);

  // ============================================================
  // Control, pointers and interrupt register
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_ptr
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          ptr_q[g] <= `PIM_RESET_VAL;
        else if (idx == g && ad_wr && !data_mode)
          ptr_q[g] <= reg_wdata;
        else if (idx == g && inc)
          ptr_q[g] <= ptr_q[g] + 16'h0001;
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_q <= 2'h0;
      sel_q <= 5'h00;
      irq_en_q <= 8'h00;
      irq_flag_q <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `PIM_OFS_CTRL)
      begin
        cmd_q <= reg_wdata[`PIM_CMD_HI:`PIM_CMD_LO];
        sel_q <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `PIM_OFS_IRQ)
        irq_en_q <= reg_wdata[7:0];
      // Reading clears the flags, but an event in the same cycle survives.
      if (reg_rd && reg_addr == `PIM_OFS_IRQ)
        irq_flag_q <= irq_event & irq_en_q;
      else
        irq_flag_q <= irq_flag_q | (irq_event & irq_en_q);
    end
  end

  // ============================================================
  // Fast link-drop detection
  pim_win_counter #(.LIMIT(`PIM_SNR_LIMIT)) u_snr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(drop_enable[1]),
    .event_in(snr_cross),
    .trip_q(trip_snr)
  );
  pim_win_counter #(.LIMIT(`PIM_MLT3_LIMIT)) u_mlt3 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(drop_enable[2]),
    .event_in(mlt3_err),
    .trip_q(trip_mlt3)
  );
  pim_win_counter #(.LIMIT(`PIM_RXERR_LIMIT)) u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(drop_enable[3]),
    .event_in(rx_err),
    .trip_q(trip_rx)
  );

  assign drop_cause = drop_enable & {descr_loss && !descr_loss_q, trip_rx, trip_mlt3, trip_snr,
    energy_lost && !energy_lost_q};

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      energy_lost_q <= 1'b0;
      descr_loss_q <= 1'b0;
      drop_stat_q <= 5'h00;
      link_drop_q <= 1'b0;
    end
    else
    begin
      energy_lost_q <= energy_lost;
      descr_loss_q <= descr_loss;
      link_drop_q <= |drop_cause;
      if (reg_rd && reg_addr == `PIM_OFS_DROP)
        drop_stat_q <= drop_cause;
      else
        drop_stat_q <= drop_stat_q | drop_cause;
    end
  end

  // ============================================================
  // Read data
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= `PIM_RESET_VAL;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PIM_OFS_IRQ: reg_rdata_q <= {irq_flag_q, irq_en_q};
        `PIM_OFS_CTRL: reg_rdata_q <= {cmd_q, 9'h000, sel_q};
        `PIM_OFS_ADDAT: reg_rdata_q <= !sel_ok ? 16'h0000 : (data_mode ? mmd_rdata : cur_ptr);
        `PIM_OFS_DROP: reg_rdata_q <= {7'h00, drop_stat_q, 4'h0};
        default: reg_rdata_q <= 16'h0000;
      endcase
    end
  end
endmodule

// *** test/pim_regs_asserts.sv ***
`timescale 1ns/1ps
// ============================================================
// Port checks for the management register slice.
module pim_regs_asserts (
  // Clock, reset and register port
  input wire ref_clk,
  input wire rst_n,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata_q,
  // Events, MMD port and link drop
  input wire [7:0] irq_event,
  input wire irq_active,
  input wire mmd_wr,
  input wire mmd_rd,
  input wire [4:0] mmd_selector,
  input wire [15:0] mmd_addr,
  input wire [15:0] mmd_wdata,
  input wire [15:0] mmd_rdata,
  input wire [4:0] drop_enable,
  input wire energy_lost,
  input wire link_drop_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire sel_ok = mmd_selector == 5'h1f || mmd_selector == 5'h03 || mmd_selector == 5'h07;
  AST_MMD_GATE: assert property ((mmd_wr || mmd_rd) |-> sel_ok && reg_addr == 5'h0e)
    else $error("MMD strobe without supported selector");
  AST_WR_PASS: assert property (mmd_wr |-> reg_wr && mmd_wdata == reg_wdata)
    else $error("MMD write data mismatch");
  AST_RD_RET: assert property (mmd_rd |=> reg_rdata_q == $past(mmd_rdata))
    else $error("read data not from MMD");
  AST_STEP: assert property ($past(mmd_wr || mmd_rd) && $stable(mmd_selector) |-> mmd_addr - $past(mmd_addr) <= 16'h1)
    else $error("pointer step above one");
  AST_NO_STRAY: assert property (reg_wr && reg_addr != 5'h0e |-> !mmd_wr)
    else $error("MMD write from other register");
  AST_IRQ_CAUSE: assert property ($rose(irq_active) |-> $past(|irq_event || (reg_wr && reg_addr == 5'h0c)))
    else $error("interrupt without cause");
  AST_IRQ_CLR: assert property (reg_rd && reg_addr == 5'h0c && irq_event == 8'h0 |=> !irq_active)
    else $error("interrupt kept after read");
  AST_DROP_EN: assert property (link_drop_q |-> $past(|drop_enable) || $past(|drop_enable, 2))
    else $error("link drop while disabled");
  AST_ENERGY: assert property (drop_enable[0] && $rose(energy_lost) |=> link_drop_q)
    else $error("energy loss did not drop link");
endmodule
bind pim_regs pim_regs_asserts u_chk (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
  .irq_event, .irq_active, .mmd_wr, .mmd_rd, .mmd_selector, .mmd_addr, .mmd_wdata, .mmd_rdata, .drop_enable,
  .energy_lost, .link_drop_q);

// *** test/pim_mmd_model.sv ***
`timescale 1ns/1ps
// ============================================================
// MMD storage behind the indirect window.
module pim_mmd_model (
  input wire ref_clk,
  input wire mmd_wr,
  input wire mmd_rd,
  input wire [4:0] mmd_selector,
  input wire [15:0] mmd_addr,
  input wire [15:0] mmd_wdata,
  output wire [15:0] mmd_rdata
);
  reg [15:0] mem_q [0:255];
  // Selectors 1f, 03 and 07 differ in bits 3:2, so each owns a bank.
  wire [7:0] idx = {mmd_selector[3:2], mmd_addr[5:0]};
  // Outside a read the lines show the complement, so a stale value cannot pass.
  assign mmd_rdata = mmd_rd ? mem_q[idx] : ~mem_q[idx];
  always @(posedge ref_clk)
  begin
    if (mmd_wr)
      mem_q[idx] <= mmd_wdata;
  end
endmodule

// *** test/pim_regs_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, v) begin n_compared++; if ((v) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, v); end end
module pim_regs_tb;
  reg ref_clk = 1'h0;
  reg rst_n = 1'h0;
  reg [4:0] reg_addr = 5'h0;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  reg [15:0] reg_wdata = 16'h0;
  reg [7:0] irq_event = 8'h0;
  reg [4:0] drop_enable = 5'h0;
  reg [4:0] cause = 5'h0;
  reg [4:0] s;
  wire [15:0] reg_rdata_q, mmd_addr, mmd_wdata, mmd_rdata;
  wire [4:0] mmd_selector;
  wire irq_active, mmd_wr, mmd_rd, link_drop_q;
  integer fail_count = 0, n_compared = 0, cyc = 0, drops = 0, i;
  pim_regs dut (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .irq_event, .irq_active,
    .mmd_wr, .mmd_rd, .mmd_selector, .mmd_addr, .mmd_wdata, .mmd_rdata, .drop_enable, .energy_lost(cause[0]),
    .snr_cross(cause[1]), .mlt3_err(cause[2]), .rx_err(cause[3]), .descr_loss(cause[4]), .link_drop_q);
  pim_mmd_model u_mmd (.ref_clk, .mmd_wr, .mmd_rd, .mmd_selector, .mmd_addr, .mmd_wdata, .mmd_rdata);
  initial forever #5 ref_clk = ~ref_clk;
  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (link_drop_q)
      drops++;
    if (cyc == 5000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  task step;
  begin
    @(posedge ref_clk);
    #1;
  end
  endtask
  task wr(input [4:0] a, input [15:0] d);
  begin
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    step;
    reg_wr = 1'h0;
    step;
  end
  endtask
  task rd(input [4:0] a, input [15:0] e);
  begin
    reg_addr = a;
    reg_rd = 1'h1;
    step;
    reg_rd = 1'h0;
    `CHK("rdata", e, reg_rdata_q)
    step;
  end
  endtask
  task t_regs;
  begin
    for (i = 12; i < 16; i++)
      rd(i[4:0], 16'h0);
    wr(5'h0c, 16'hffff);
    rd(5'h0c, 16'h00ff);
    wr(5'h0f, 16'hffff);
    rd(5'h0f, 16'h0);
    rd(5'h03, 16'h0);
  end
  endtask
  task t_irq;
  begin
    wr(5'h0c, 16'h0080);
    irq_event = 8'hc0;
    step;
    irq_event = 8'h0;
    `CHK("irq", 1'h1, irq_active)
    rd(5'h0c, 16'h8080);
    `CHK("irq", 1'h0, irq_active)
  end
  endtask
  task t_mmd;
  begin
    for (i = 1; i < 4; i++)
    begin
      s = (i == 1) ? 5'h1f : (i == 2) ? 5'h03 : 5'h07;
      wr(5'h0d, {11'h0, s});
      wr(5'h0e, 16'h0020);
      rd(5'h0e, 16'h0020);
      wr(5'h0d, {i[1:0], 9'h0, s});
      wr(5'h0e, 16'h1230 + i[15:0]);
      `CHK("ptr", 16'h20 + (i > 1), mmd_addr)
      wr(5'h0d, {11'h0, s});
      wr(5'h0e, 16'h0020);
      wr(5'h0d, {i[1:0], 9'h0, s});
      rd(5'h0e, 16'h1230 + i[15:0]);
      `CHK("ptr", 16'h20 + (i == 2), mmd_addr)
    end
    wr(5'h0d, 16'h4005);
    wr(5'h0e, 16'hbeef);
    `CHK("ptr", 16'h0, mmd_addr)
    rd(5'h0e, 16'h0);
  end
  endtask
  task t_drop;
  begin
    drop_enable = 5'h1f;
    // Bursts stay short of twice the limit, so fixed windows trip once.
    for (i = 0; i < 5; i++)
    begin
      cause[i] = 1'h1;
      repeat ((i == 3) ? 63 : 39) step;
      cause = 5'h0;
      repeat (3) step;
      rd(5'h0f, 16'h10 << i);
    end
    `CHK("drops", 5, drops)
  end
  endtask
  task report_and_stop;
  begin
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1;
    rst_n = 1'h1;
    t_regs;
    t_irq;
    t_mmd;
    t_drop;
    report_and_stop;
  end
endmodule
